// File: design/sis_pkg.sv
// Constants for the switch input status register slice
// How it works
// - Matrix bits 11..6 give input 15 result against rows 9 down to 4.
// - Matrix bits 5..0 give input 14 result against rows 9 down to 4.
// - Analog result 0 at offset Ah, 24 bits, resets zero, bits 23..20 zero.
// - Analog result 0 bits 9..0 hold channel 0 code, LSB at bit 0.
// - Analog result 0 bits 19..10 hold channel 1 code, LSB at bit 10.
// - Offset Bh holds channel 2 low and channel 3 high.
// - Offset Ch holds channel 4 low and channel 5 high.
// - Offset Dh holds channel 6 low and channel 7 high.
// - All fields of these registers are read-only to the host.
// - Matrix status at 9h, resets zero, upper bits vs shared threshold.
package sis_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam int CODE_W = 10;
  localparam int NUM_CH = 8;
  localparam int NUM_COLS = 6;
  localparam int NUM_SHARED = 12;
  localparam logic [ADDR_W-1:0] OFF_MATRIX_UPPER = 6'h09;
  localparam logic [ADDR_W-1:0] OFF_ANALOG_0_1 = 6'h0A;
  localparam logic [ADDR_W-1:0] OFF_ANALOG_2_3 = 6'h0B;
  localparam logic [ADDR_W-1:0] OFF_ANALOG_4_5 = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_ANALOG_6_7 = 6'h0D;
  localparam int ROW14_LSB = 0;
  localparam int ROW15_LSB = 6;
  localparam int SHARED_LSB = 12;
  localparam int LOW_CODE_LSB = 0;
  localparam int HIGH_CODE_LSB = 10;
  localparam int RSVD_LSB = 20;
  localparam logic [DATA_W-1:0] RESET_VALUE = 24'h000000;
endpackage

// File: design/sis_status_regs.sv
// Read-only matrix and analog result registers
`timescale 1ns/10ps
module sis_status_regs #(
  parameter int CODE_W = sis_pkg::CODE_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Results from the polling and conversion logic
  input wire logic [sis_pkg::NUM_COLS-1:0] matrix_row14_i,
  input wire logic [sis_pkg::NUM_COLS-1:0] matrix_row15_i,
  input wire logic [sis_pkg::NUM_SHARED-1:0] shared_threshold_i,
  input wire logic [sis_pkg::NUM_CH*CODE_W-1:0] adc_codes_i,
  input wire logic result_valid_i,
  // Register port
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [sis_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [sis_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [sis_pkg::DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o
);
  // Packing leaves exactly four reserved bits only for ten-bit codes
  if (CODE_W != sis_pkg::CODE_W) begin : g_code_width_check
    $error("code width must be 10");
  end

  // ----------------------------------------
  // Result storage
  // ----------------------------------------
  logic [sis_pkg::DATA_W-1:0] matrix_q;
  logic [CODE_W-1:0] code_q [sis_pkg::NUM_CH];

  // Register contents change only from reset and the result side, never from writes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      matrix_q <= sis_pkg::RESET_VALUE;
    end else if (result_valid_i) begin
      matrix_q <= {shared_threshold_i, matrix_row15_i, matrix_row14_i};
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < sis_pkg::NUM_CH; i++) begin
        code_q[i] <= '0;
      end
    end else if (result_valid_i) begin
      for (int i = 0; i < sis_pkg::NUM_CH; i++) begin
        code_q[i] <= adc_codes_i[i*CODE_W +: CODE_W];
      end
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  function automatic logic [sis_pkg::DATA_W-1:0] pack_pair(
    input logic [CODE_W-1:0] lo,
    input logic [CODE_W-1:0] hi
  );
    pack_pair = {4'h0, hi, lo};
  endfunction

  logic [sis_pkg::DATA_W-1:0] rdata_d;
  always_comb begin
    case (reg_addr_i)
      sis_pkg::OFF_MATRIX_UPPER: rdata_d = matrix_q;
      sis_pkg::OFF_ANALOG_0_1: rdata_d = pack_pair(code_q[0], code_q[1]);
      sis_pkg::OFF_ANALOG_2_3: rdata_d = pack_pair(code_q[2], code_q[3]);
      sis_pkg::OFF_ANALOG_4_5: rdata_d = pack_pair(code_q[4], code_q[5]);
      sis_pkg::OFF_ANALOG_6_7: rdata_d = pack_pair(code_q[6], code_q[7]);
      default: rdata_d = sis_pkg::RESET_VALUE;
    endcase
  end

  // Writes are accepted and dropped; no answer is given to them
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // Read data stands for one cycle and returns to zero after it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= sis_pkg::RESET_VALUE;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_d : sis_pkg::RESET_VALUE;
    end
  end

  // ----------------------------------------
  // Matrix checks
  // ----------------------------------------
  row15_bits_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    result_valid_i ##1 reg_rd_i && reg_addr_i == sis_pkg::OFF_MATRIX_UPPER
    |=> reg_rdata_o[11:6] == $past(matrix_row15_i, 2))
    else $error("row 15 bits wrong");
  row14_bits_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    result_valid_i ##1 reg_rd_i && reg_addr_i == sis_pkg::OFF_MATRIX_UPPER
    |=> reg_rdata_o[5:0] == $past(matrix_row14_i, 2))
    else $error("row 14 bits wrong");
  shared_bits_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    result_valid_i ##1 reg_rd_i && reg_addr_i == sis_pkg::OFF_MATRIX_UPPER
    |=> reg_rdata_o[23:12] == $past(shared_threshold_i, 2))
    else $error("shared threshold bits wrong");
  matrix_read_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == sis_pkg::OFF_MATRIX_UPPER
    |=> reg_rdata_o == $past(matrix_q))
    else $error("matrix word wrong");
  write_ignored_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    reg_wr_i && !result_valid_i |=> $stable(matrix_q))
    else $error("write changed register");
  hold_contents_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    !result_valid_i |=> $stable(matrix_q) && $stable(codes_flat))
    else $error("contents changed without capture");

  // ----------------------------------------
  // Analog result checks
  // ----------------------------------------
  // All stored codes side by side, so one stability test covers them
  logic [sis_pkg::NUM_CH*CODE_W-1:0] codes_flat;
  always_comb begin
    for (int i = 0; i < sis_pkg::NUM_CH; i++) begin
      codes_flat[i*CODE_W +: CODE_W] = code_q[i];
    end
  end
  rsvd_zero_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    $past(reg_rd_i) && $past(reg_addr_i) != sis_pkg::OFF_MATRIX_UPPER
    |-> reg_rdata_o[23:20] == 4'h0)
    else $error("reserved bits not zero");
  ch0_code_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_0_1
    |=> reg_rdata_o[9:0] == $past(code_q[0]))
    else $error("channel 0 code wrong");
  ch1_code_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_0_1
    |=> reg_rdata_o[19:10] == $past(code_q[1]))
    else $error("channel 1 code wrong");
  ch0_capture_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    result_valid_i ##1 reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_0_1
    |=> reg_rdata_o[9:0] == $past(adc_codes_i[9:0], 2))
    else $error("channel 0 capture wrong");
  ch1_capture_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    result_valid_i ##1 reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_0_1
    |=> reg_rdata_o[19:10] == $past(adc_codes_i[19:10], 2))
    else $error("channel 1 capture wrong");
  ch2_code_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    result_valid_i ##1 reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_2_3
    |=> reg_rdata_o[9:0] == $past(adc_codes_i[29:20], 2))
    else $error("channel 2 code wrong");
  ch3_code_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    result_valid_i ##1 reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_2_3
    |=> reg_rdata_o[19:10] == $past(adc_codes_i[39:30], 2))
    else $error("channel 3 code wrong");
  ch4_code_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    result_valid_i ##1 reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_4_5
    |=> reg_rdata_o[9:0] == $past(adc_codes_i[49:40], 2))
    else $error("channel 4 code wrong");
  ch5_code_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    result_valid_i ##1 reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_4_5
    |=> reg_rdata_o[19:10] == $past(adc_codes_i[59:50], 2))
    else $error("channel 5 code wrong");
  ch6_code_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    result_valid_i ##1 reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_6_7
    |=> reg_rdata_o[9:0] == $past(adc_codes_i[69:60], 2))
    else $error("channel 6 code wrong");
  ch7_code_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    result_valid_i ##1 reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_6_7
    |=> reg_rdata_o[19:10] == $past(adc_codes_i[79:70], 2))
    else $error("channel 7 code wrong");
  word_2_3_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_2_3
    |=> reg_rdata_o == {4'h0, $past(code_q[3]), $past(code_q[2])})
    else $error("inputs 2 and 3 word wrong");
  word_4_5_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_4_5
    |=> reg_rdata_o == {4'h0, $past(code_q[5]), $past(code_q[4])})
    else $error("inputs 4 and 5 word wrong");
  word_6_7_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == sis_pkg::OFF_ANALOG_6_7
    |=> reg_rdata_o == {4'h0, $past(code_q[7]), $past(code_q[6])})
    else $error("inputs 6 and 7 word wrong");
  codes_write_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    reg_wr_i && !result_valid_i |=> $stable(codes_flat))
    else $error("write changed a code");

  // ----------------------------------------
  // Read port checks
  // ----------------------------------------
  rvalid_follows_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    reg_rd_i |=> reg_rvalid_o ##1 (reg_rvalid_o == $past(reg_rd_i)))
    else $error("read answer missing");
  read_idle_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    !reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == sis_pkg::RESET_VALUE)
    else $error("answer without a read");
  unmapped_zero_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    reg_rd_i && (reg_addr_i < sis_pkg::OFF_MATRIX_UPPER
    || reg_addr_i > sis_pkg::OFF_ANALOG_6_7)
    |=> reg_rdata_o == sis_pkg::RESET_VALUE)
    else $error("unmapped offset read not zero");
  write_no_answer_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    reg_wr_i && !reg_rd_i && reg_wdata_i != sis_pkg::RESET_VALUE
    |=> !reg_rvalid_o && reg_rdata_o == sis_pkg::RESET_VALUE)
    else $error("write produced an answer");
endmodule

// File: verification/sis_host_model.sv
// Host model issuing register reads and writes
`timescale 1ns/10ps
module sis_host_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic rd_o = 1'b0,
  output logic wr_o = 1'b0,
  output logic [5:0] addr_o = 6'h00,
  output logic [23:0] wdata_o = 24'h000000,
  input wire logic [23:0] rdata_i,
  input wire logic rvalid_i
);
  // Answer is sampled one edge after the request is taken
  task automatic rd(input logic [5:0] a, output logic [24:0] r);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    r = {rvalid_i, rdata_i};
  endtask
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
endmodule

// File: verification/test_switch_input_status_regs.sv
// Self-checking bench for the status register slice
`timescale 1ns/10ps
module test_switch_input_status_regs;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic vld = 1'b0;
  logic [5:0] r14 = 6'h00;
  logic [5:0] r15 = 6'h00;
  logic [11:0] sh = 12'h000;
  logic [79:0] codes = 80'h0;
  logic rd, wr, rv;
  logic [5:0] ad;
  logic [23:0] wd, rdat;
  logic [24:0] got;
  logic [9:0] c [8];
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  always #2 clk_i = ~clk_i;
  sis_status_regs u_sis_status_regs (.clk_i(clk_i), .resetn_i(resetn_i),
    .matrix_row14_i(r14), .matrix_row15_i(r15), .shared_threshold_i(sh),
    .adc_codes_i(codes), .result_valid_i(vld), .reg_rd_i(rd),
    .reg_wr_i(wr), .reg_addr_i(ad), .reg_wdata_i(wd),
    .reg_rdata_o(rdat), .reg_rvalid_o(rv));
  sis_host_model u_sis_host_model (.clk_i(clk_i), .rd_o(rd), .wr_o(wr),
    .addr_o(ad), .wdata_o(wd), .rdata_i(rdat), .rvalid_i(rv));
  task automatic rdchk(input logic [5:0] a, input logic [23:0] e);
    u_sis_host_model.rd(a, got);
    checks++;
    if (got !== {1'b1, e}) begin
      fails++;
      $display("CHECK FAILED reg %h expected %h seen %h", a, e, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int k = 0; k < 5; k++) rdchk(6'(9 + k), 24'h0);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) c[i] = 10'(513 + 67 * i);
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) codes[10*i +: 10] <= c[i];
    r14 <= 6'h25;
    r15 <= 6'h1A;
    sh <= 12'hA5C;
    vld <= 1'b1;
    @(posedge clk_i);
    vld <= 1'b0;
    rdchk(6'h09, 24'hA5C6A5);
    for (int k = 0; k < 4; k++) rdchk(6'(10 + k), {4'h0, c[2*k+1], c[2*k]});
    $display("test field layout done");
    u_sis_host_model.wr(6'h0A, 24'hFFFFFF);
    u_sis_host_model.wr(6'h09, 24'h000000);
    rdchk(6'h0A, {4'h0, c[1], c[0]});
    rdchk(6'h09, 24'hA5C6A5);
    rdchk(6'h0E, 24'h0);
    $display("test writes ignored done");
    resetn_i <= 1'b0;
    @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int k = 0; k < 5; k++) rdchk(6'(9 + k), 24'h0);
    $display("test reset clears done");
    conclude();
  end
endmodule
